// file: sag_pkg.sv
// Constants used by the serial register port decode; the byte shifter uses none of them
//
// Summary of operation
// - Single access 0x30-0x3D is a command strobe; eight of those addresses fire one
// - Burst read 0x30-0x3D returns read-only status
// - Address 0x3F reads receive FIFO; writes ignored
// - Output configuration survives sleep unchanged
// - Output-2 bit 6 inverts selected signal
// - Output-2 bits 5:0 select; reset 41, bit7 zero
// - Output-1 bit 7 sets drive strength, all pins
// - Output-1 bit 6 inverts selected signal
// - Output-1 bits 5:0 select; reset 46 three-state
// - Header bit 6 selects single/burst, bit 7 write/read
`default_nettype none
package sag_pkg;
    // ****************************************
    // Header byte layout
    // ****************************************
    localparam int HDR_RD_BIT    = 7;
    localparam int HDR_BURST_BIT = 6;
    // ****************************************
    // Address map
    // ****************************************
    localparam logic [5:0] ADDR_OUT2_CFG  = 6'h00;
    localparam logic [5:0] ADDR_OUT1_CFG  = 6'h01;
    localparam logic [5:0] ADDR_TOP_LO    = 6'h30;
    localparam logic [5:0] ADDR_TOP_HI    = 6'h3d;
    localparam logic [5:0] ADDR_RESET     = 6'h30;
    localparam logic [5:0] ADDR_XOFF      = 6'h32;
    localparam logic [5:0] ADDR_CAL       = 6'h33;
    localparam logic [5:0] ADDR_RX        = 6'h34;
    localparam logic [5:0] ADDR_IDLE      = 6'h36;
    localparam logic [5:0] ADDR_PWD       = 6'h39;
    localparam logic [5:0] ADDR_FLUSH     = 6'h3a;
    localparam logic [5:0] ADDR_NOP       = 6'h3d;
    localparam logic [5:0] ADDR_PART_NO   = 6'h30;
    localparam logic [5:0] ADDR_VERSION   = 6'h31;
    localparam logic [5:0] ADDR_FREQ_EST  = 6'h32;
    localparam logic [5:0] ADDR_CRC       = 6'h33;
    localparam logic [5:0] ADDR_SIG_STR   = 6'h34;
    localparam logic [5:0] ADDR_STATE     = 6'h35;
    localparam logic [5:0] ADDR_PKTSTAT   = 6'h38;
    localparam logic [5:0] ADDR_RX_FILL   = 6'h3b;
    localparam logic [5:0] ADDR_RX_FIFO   = 6'h3f;
    // ****************************************
    // Configuration fields and reset values
    // ****************************************
    localparam int         CFG_DS_BIT     = 7;
    localparam int         CFG_INV_BIT    = 6;
    localparam int         CFG_SEL_MSB    = 5;
    localparam logic [7:0] OUT2_CFG_RST   = 8'h29;
    localparam logic [7:0] OUT1_CFG_RST   = 8'h2e;
    localparam logic [7:0] OUT2_CFG_WMASK = 8'h7f;
    localparam logic [5:0] SEL_TRISTATE   = 6'h2e;
    // ****************************************
    // Strobe vector positions
    // ****************************************
    localparam int STB_RESET = 0;
    localparam int STB_XOFF  = 1;
    localparam int STB_CAL   = 2;
    localparam int STB_RX    = 3;
    localparam int STB_IDLE  = 4;
    localparam int STB_PWD   = 5;
    localparam int STB_FLUSH = 6;
    localparam int STB_NOP   = 7;
    localparam int STB_COUNT = 8;

    typedef enum logic [0:0] {
        SAG_HDR  = 1'b0,
        SAG_DATA = 1'b1
    } sag_state_t;
endpackage : sag_pkg
`default_nettype wire

// file: sag_byte_if.sv
// Byte-level carrier between the serial shifter and the register decode
`default_nettype none
`timescale 1ns/100ps
interface sag_byte_if;
    logic       frame_start; // Pulse: select asserted
    logic       byte_valid;  // Pulse: received byte complete
    logic [7:0] rx_byte;     // Received byte
    logic       tx_load;     // Pulse: load next outgoing byte
    logic [7:0] tx_byte;     // Next outgoing byte
    modport shifter (output frame_start, output byte_valid, output rx_byte,
                     input tx_load, input tx_byte);
    modport decode (input frame_start, input byte_valid, input rx_byte,
                    output tx_load, output tx_byte);
endinterface : sag_byte_if
`default_nettype wire

// file: sag_shifter.sv
// Serial pin synchroniser and byte shifter, mode 0, MSB first
`default_nettype none
`timescale 1ns/100ps
module sag_shifter (
    input  wire logic  core_clk,  // 10 MHz core clock
    input  wire logic  rst,       // Async reset, active high
    input  wire logic  sclk_pin,  // Serial clock from master
    input  wire logic  csn_pin,   // Chip select, active low
    input  wire logic  si_pin,    // Serial data in
    output logic       so_out,    // Serial data out
    output logic       so_oe_n,   // Low while driving serial out
    sag_byte_if.shifter bus       // Byte carrier
);
    logic [2:0] sync1_q, sync2_q, last_q;
    logic [2:0] sync1_d, sync2_d, last_d;
    logic [7:0] rx_q, rx_d, tx_q, tx_d;
    logic [2:0] cnt_q, cnt_d;
    logic       bv_q, bv_d, fs_q, fs_d;
    logic       sck_rise, sck_fall, sel;

    // ****************************************
    // Two-stage synchronisers on all pins
    // ****************************************
    // Slow master only: sclk must stay well below core_clk / 4
    always_comb begin
        sync1_d  = {sclk_pin, csn_pin, si_pin};
        sync2_d  = sync1_q;
        last_d   = sync2_q;
        sel      = !sync2_q[1];
        sck_rise = sel && sync2_q[2] && !last_q[2];
        sck_fall = sel && !sync2_q[2] && last_q[2];
        rx_d     = rx_q;
        tx_d     = tx_q;
        cnt_d    = cnt_q;
        bv_d     = 1'b0;
        fs_d     = !sync2_q[1] && last_q[1];
        if (!sel) begin
            cnt_d = 3'h0;
        end else if (sck_rise) begin
            rx_d  = {rx_q[6:0], sync2_q[0]};
            cnt_d = cnt_q + 3'h1;
            bv_d  = (cnt_q == 3'h7);
        end else if (sck_fall && cnt_q != 3'h0) begin
            tx_d = {tx_q[6:0], 1'b0};
        end
        // Byte boundary: no shift on the following fall, so a load here is seen
        if (bus.tx_load) begin
            tx_d = bus.tx_byte;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sync1_q <= 3'b010;
            sync2_q <= 3'b010;
            last_q  <= 3'b010;
            rx_q    <= 8'h00;
            tx_q    <= 8'h00;
            cnt_q   <= 3'h0;
            bv_q    <= 1'b0;
            fs_q    <= 1'b0;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            last_q  <= last_d;
            rx_q    <= rx_d;
            tx_q    <= tx_d;
            cnt_q   <= cnt_d;
            bv_q    <= bv_d;
            fs_q    <= fs_d;
        end
    end

    assign bus.rx_byte     = rx_q;
    assign bus.byte_valid  = bv_q;
    assign bus.frame_start = fs_q;
    assign so_out          = tx_q[7];
    assign so_oe_n         = !sel;
endmodule : sag_shifter
`default_nettype wire

// file: sag_regmap.sv
// Serial register port decode: strobes, status, FIFO and output configuration
`default_nettype none
`timescale 1ns/100ps
module sag_regmap (
    input  wire logic        core_clk,          // 10 MHz core clock
    input  wire logic        rst,               // Async reset, active high
    input  wire logic        sclk_pin,          // Serial clock pin
    input  wire logic        csn_pin,           // Chip select pin, active low
    input  wire logic        si_pin,            // Serial data in pin
    output logic             so_out,            // Serial data out
    output logic             so_oe_n,           // Low while driving serial out
    input  wire logic [7:0]  chip_status,       // Status byte sent with headers
    input  wire logic [7:0]  part_number,       // Part number status
    input  wire logic [7:0]  chip_version,      // Version status
    input  wire logic [7:0]  freq_offset_est,   // Frequency estimate status
    input  wire logic [7:0]  checksum_stat,     // Checksum status
    input  wire logic [7:0]  signal_strength,   // Signal strength status
    input  wire logic [7:0]  radio_state,       // State machine state
    input  wire logic [7:0]  packet_pin_status, // Packet status
    input  wire logic [7:0]  rx_fill_count,     // Receive byte count
    input  wire logic [7:0]  rx_fifo_data,      // FIFO head, shown before pop
    output logic             rx_fifo_pop,       // Pulse: FIFO byte consumed
    output logic             reset_strobe,      // Command strobe pulses
    output logic             crystal_off_strobe,
    output logic             calibrate_strobe,
    output logic             receive_strobe,
    output logic             idle_strobe,
    output logic             power_down_strobe,
    output logic             flush_rx_strobe,
    output logic             no_op_strobe,
    input  wire logic        sleep_active,      // Chip in sleep state
    input  wire logic [63:0] output_sources,    // Selectable internal signals
    output logic             general_output_2,  // Output 2 level
    output logic             output2_oe_n,      // Low while output 2 drives
    output logic             general_output_1,  // Output 1 level
    output logic             output1_oe_n,      // Low while output 1 drives
    output logic             output_drive_strength // High drive for all outputs
);
    sag_byte_if bif ();

    sag_shifter u_shifter (
        .core_clk (core_clk),
        .rst      (rst),
        .sclk_pin (sclk_pin),
        .csn_pin  (csn_pin),
        .si_pin   (si_pin),
        .so_out   (so_out),
        .so_oe_n  (so_oe_n),
        .bus      (bif.shifter)
    );

    sag_pkg::sag_state_t st_q, st_d;
    logic [5:0] addr_q, addr_d;
    logic       rd_q, rd_d, burst_q, burst_d;
    logic       load_q, load_d, stat_q, stat_d, pop_q, pop_d;
    logic [7:0] cfg2_q, cfg2_d, cfg1_q, cfg1_d;
    logic [sag_pkg::STB_COUNT-1:0] stb_q, stb_d;
    logic [7:0] tx_q, tx_d;
    logic [5:0] hdr_addr;
    logic       hdr_take, data_take, is_strobe;

    // ****************************************
    // Decode functions
    // ****************************************
    function automatic logic [sag_pkg::STB_COUNT-1:0] strobe_dec(input logic [5:0] a);
        strobe_dec = '0;
        case (a)
            sag_pkg::ADDR_RESET: strobe_dec[sag_pkg::STB_RESET] = 1'b1;
            sag_pkg::ADDR_XOFF:  strobe_dec[sag_pkg::STB_XOFF]  = 1'b1;
            sag_pkg::ADDR_CAL:   strobe_dec[sag_pkg::STB_CAL]   = 1'b1;
            sag_pkg::ADDR_RX:    strobe_dec[sag_pkg::STB_RX]    = 1'b1;
            sag_pkg::ADDR_IDLE:  strobe_dec[sag_pkg::STB_IDLE]  = 1'b1;
            sag_pkg::ADDR_PWD:   strobe_dec[sag_pkg::STB_PWD]   = 1'b1;
            sag_pkg::ADDR_FLUSH: strobe_dec[sag_pkg::STB_FLUSH] = 1'b1;
            sag_pkg::ADDR_NOP:   strobe_dec[sag_pkg::STB_NOP]   = 1'b1;
            default:             strobe_dec = '0;
        endcase
    endfunction

    // Burst read of the top range reaches status; 0x3F the FIFO, 0x00-0x01 configuration, others zero
    function automatic logic [7:0] read_dec(input logic [5:0] a, input logic b);
        read_dec = 8'h00;
        if (a == sag_pkg::ADDR_RX_FIFO) begin
            read_dec = rx_fifo_data;
        end else if (a >= sag_pkg::ADDR_TOP_LO) begin
            if (b) begin
                case (a)
                    sag_pkg::ADDR_PART_NO:  read_dec = part_number;
                    sag_pkg::ADDR_VERSION:  read_dec = chip_version;
                    sag_pkg::ADDR_FREQ_EST: read_dec = freq_offset_est;
                    sag_pkg::ADDR_CRC:      read_dec = checksum_stat;
                    sag_pkg::ADDR_SIG_STR:  read_dec = signal_strength;
                    sag_pkg::ADDR_STATE:    read_dec = radio_state;
                    sag_pkg::ADDR_PKTSTAT:  read_dec = packet_pin_status;
                    sag_pkg::ADDR_RX_FILL:  read_dec = rx_fill_count;
                    default:               read_dec = 8'h00;
                endcase
            end
        end else if (a == sag_pkg::ADDR_OUT2_CFG) begin
            read_dec = cfg2_q;
        end else if (a == sag_pkg::ADDR_OUT1_CFG) begin
            read_dec = cfg1_q;
        end
    endfunction

    // ****************************************
    // Transaction sequencing
    // ****************************************
    assign hdr_addr  = bif.rx_byte[5:0];
    assign hdr_take  = bif.byte_valid && st_q == sag_pkg::SAG_HDR;
    assign data_take = bif.byte_valid && st_q == sag_pkg::SAG_DATA;
    assign is_strobe = !bif.rx_byte[sag_pkg::HDR_BURST_BIT] &&
                       hdr_addr >= sag_pkg::ADDR_TOP_LO && hdr_addr <= sag_pkg::ADDR_TOP_HI;

    always_comb begin
        st_d    = st_q;
        addr_d  = addr_q;
        rd_d    = rd_q;
        burst_d = burst_q;
        load_d  = 1'b0;
        stat_d  = 1'b0;
        pop_d   = 1'b0;
        cfg2_d  = cfg2_q;
        cfg1_d  = cfg1_q;
        stb_d   = '0;
        tx_d    = tx_q;
        if (bif.frame_start) begin
            st_d   = sag_pkg::SAG_HDR;
            stat_d = 1'b1;
        end else if (hdr_take) begin
            addr_d  = hdr_addr;
            rd_d    = bif.rx_byte[sag_pkg::HDR_RD_BIT];
            burst_d = bif.rx_byte[sag_pkg::HDR_BURST_BIT];
            if (is_strobe) begin
                stb_d  = strobe_dec(hdr_addr);
                stat_d = 1'b1;
            end else begin
                st_d   = sag_pkg::SAG_DATA;
                load_d = bif.rx_byte[sag_pkg::HDR_RD_BIT];
            end
        end else if (data_take) begin
            if (rd_q) begin
                pop_d = (addr_q == sag_pkg::ADDR_RX_FIFO);
            end else begin
                case (addr_q)
                    sag_pkg::ADDR_OUT2_CFG: cfg2_d = bif.rx_byte & sag_pkg::OUT2_CFG_WMASK;
                    sag_pkg::ADDR_OUT1_CFG: cfg1_d = bif.rx_byte;
                    default:                cfg1_d = cfg1_q;
                endcase
            end
            if (burst_q) begin
                // Burst walks the configuration space; FIFO and status stay put
                if (addr_q < sag_pkg::ADDR_TOP_LO) begin
                    addr_d = addr_q + 6'h01;
                end
                load_d = rd_q && addr_q != sag_pkg::ADDR_RX_FIFO;
            end else begin
                st_d   = sag_pkg::SAG_HDR;
                stat_d = 1'b1;
            end
        end
        // FIFO head is only valid the cycle after the pop has moved it on
        if (pop_q && burst_q) begin
            load_d = 1'b1;
        end
        // Chip reset strobe restores defaults; sleep alone never does
        if (stb_q[sag_pkg::STB_RESET]) begin
            cfg2_d = sag_pkg::OUT2_CFG_RST;
            cfg1_d = sag_pkg::OUT1_CFG_RST;
        end
        if (load_q) begin
            tx_d = read_dec(addr_q, burst_q);
        end else if (stat_q) begin
            tx_d = chip_status;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_q    <= sag_pkg::SAG_HDR;
            addr_q  <= 6'h00;
            rd_q    <= 1'b0;
            burst_q <= 1'b0;
            load_q  <= 1'b0;
            stat_q  <= 1'b0;
            pop_q   <= 1'b0;
            cfg2_q  <= sag_pkg::OUT2_CFG_RST;
            cfg1_q  <= sag_pkg::OUT1_CFG_RST;
            stb_q   <= '0;
            tx_q    <= 8'h00;
        end else begin
            st_q    <= st_d;
            addr_q  <= addr_d;
            rd_q    <= rd_d;
            burst_q <= burst_d;
            load_q  <= load_d;
            stat_q  <= stat_d;
            pop_q   <= pop_d;
            cfg2_q  <= cfg2_d;
            cfg1_q  <= cfg1_d;
            stb_q   <= stb_d;
            tx_q    <= tx_d;
        end
    end

    // Byte loaded one cycle after the decision, so a popped FIFO head settles
    assign bif.tx_byte = tx_d;
    assign bif.tx_load = load_q || stat_q;
    assign rx_fifo_pop = pop_q;

    assign reset_strobe       = stb_q[sag_pkg::STB_RESET];
    assign crystal_off_strobe = stb_q[sag_pkg::STB_XOFF];
    assign calibrate_strobe   = stb_q[sag_pkg::STB_CAL];
    assign receive_strobe     = stb_q[sag_pkg::STB_RX];
    assign idle_strobe        = stb_q[sag_pkg::STB_IDLE];
    assign power_down_strobe  = stb_q[sag_pkg::STB_PWD];
    assign flush_rx_strobe    = stb_q[sag_pkg::STB_FLUSH];
    assign no_op_strobe       = stb_q[sag_pkg::STB_NOP];

    // ****************************************
    // Output selection
    // ****************************************
    assign general_output_2 = output_sources[cfg2_q[sag_pkg::CFG_SEL_MSB:0]]
                              ^ cfg2_q[sag_pkg::CFG_INV_BIT];
    assign general_output_1 = output_sources[cfg1_q[sag_pkg::CFG_SEL_MSB:0]]
                              ^ cfg1_q[sag_pkg::CFG_INV_BIT];
    assign output2_oe_n = cfg2_q[sag_pkg::CFG_SEL_MSB:0] == sag_pkg::SEL_TRISTATE;
    assign output1_oe_n = cfg1_q[sag_pkg::CFG_SEL_MSB:0] == sag_pkg::SEL_TRISTATE;
    assign output_drive_strength = cfg1_q[sag_pkg::CFG_DS_BIT];

    // ****************************************
    // Assertions
    // ****************************************
    strobe_fires_a: assert property (@(posedge core_clk) disable iff (rst)
        hdr_take && is_strobe |=> $onehot(stb_q) ##1 stb_q == '0)
        else $error("strobe header did not give one strobe pulse");
    status_read_a: assert property (@(posedge core_clk) disable iff (rst)
        hdr_take && bif.rx_byte == 8'hf5 |=> bif.tx_load && bif.tx_byte == radio_state)
        else $error("burst status read did not return state");
    fifo_pop_a: assert property (@(posedge core_clk) disable iff (rst)
        rx_fifo_pop |-> $past(data_take) && addr_q == sag_pkg::ADDR_RX_FIFO && rd_q)
        else $error("fifo pop outside fifo read");
    sleep_keep_a: assert property (@(posedge core_clk) disable iff (rst)
        sleep_active && !data_take && !stb_q[sag_pkg::STB_RESET]
        |=> $stable(cfg2_q) && $stable(cfg1_q))
        else $error("configuration changed without write");
    invert2_a: assert property (@(posedge core_clk) disable iff (rst)
        general_output_2 != output_sources[cfg2_q[5:0]] |-> cfg2_q[6])
        else $error("output 2 inverted without invert bit");
    unused_bit_a: assert property (@(posedge core_clk) disable iff (rst)
        data_take && !rd_q && addr_q == 6'h00 |=> cfg2_q == {1'b0, $past(bif.rx_byte[6:0])})
        else $error("output 2 configuration write wrong");
    drive_str_a: assert property (@(posedge core_clk) disable iff (rst)
        data_take && !rd_q && addr_q == 6'h01 |=> output_drive_strength == $past(bif.rx_byte[7]))
        else $error("drive strength not taken from write");
    reset_cfg_a: assert property (@(posedge core_clk) disable iff (rst)
        reset_strobe |=> cfg1_q == 8'h2e && cfg2_q == 8'h29 && output1_oe_n)
        else $error("reset strobe did not restore defaults");
    burst_next_a: assert property (@(posedge core_clk) disable iff (rst)
        data_take && burst_q && rd_q && addr_q != sag_pkg::ADDR_RX_FIFO
        |=> bif.tx_load && st_q == sag_pkg::SAG_DATA)
        else $error("burst read did not load next byte");
    fifo_reload_a: assert property (@(posedge core_clk) disable iff (rst)
        rx_fifo_pop && burst_q |=> bif.tx_load && bif.tx_byte == rx_fifo_data)
        else $error("burst fifo read did not load next head");
    ignore_wr_a: assert property (@(posedge core_clk) disable iff (rst)
        data_take && !rd_q && addr_q > 6'h01 && !stb_q[sag_pkg::STB_RESET]
        |=> $stable(cfg1_q) && $stable(cfg2_q))
        else $error("write to unused address changed state");
endmodule : sag_regmap
`default_nettype wire

// file: sag_master_model.sv
// Serial port master model that drives the register port pins
`timescale 1ns/100ps
`default_nettype none
module sag_master_model (
    input  wire logic core_clk, // Pacing clock
    input  wire logic so_out,   // Serial data from device
    output var logic  sclk_pin, // Serial clock, idle low
    output var logic  csn_pin,  // Chip select, active low
    output var logic  si_pin    // Serial data to device
);
    // Phases kept above the four-cycle minimum of the synchronisers
    localparam int HALF = 6;
    initial begin
        sclk_pin = 1'b0;
        csn_pin  = 1'b1;
        si_pin   = 1'b0;
    end
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            si_pin <= tx[i];
            wait_cyc(HALF);
            rx[i] = so_out;
            sclk_pin <= 1'b1;
            wait_cyc(HALF);
            sclk_pin <= 1'b0;
        end
    endtask
    task automatic access(input logic rd_op, input logic burst, input logic [5:0] addr,
                          input logic [7:0] wr [4], input int n, output logic [7:0] rd [4]);
        logic [7:0] hdr;
        logic [7:0] junk;
        hdr = {rd_op, burst, addr};
        @(posedge core_clk);
        csn_pin <= 1'b0;
        wait_cyc(8);
        xfer(hdr, junk);
        for (int k = 0; k < n; k++) xfer(wr[k], rd[k]);
        wait_cyc(HALF);
        csn_pin <= 1'b1;
        si_pin  <= ~si_pin; // Released line must not show a stale bit
        wait_cyc(8);
    endtask
endmodule // sag_master_model
`default_nettype wire

// file: spi_address_map_gdo_config_bench.sv
// Self-checking bench for the serial register port decode
`timescale 1ns/100ps
`default_nettype none
module spi_address_map_gdo_config_bench;
    logic        core_clk, rst, sclk_pin, csn_pin, si_pin, so_out, so_oe_n, sleep_active;
    logic        rx_fifo_pop, go2, oe2_n, go1, oe1_n, ds;
    logic [7:0]  chip_status, rx_fifo_data, stb;
    logic [7:0]  stat [8];
    logic [7:0]  wr [4];
    logic [7:0]  rd [4];
    logic [63:0] output_sources;
    int          bad_count, n_checks, pops;
    int          stb_cnt [8];
    sag_regmap i_dut (.core_clk(core_clk), .rst(rst), .sclk_pin(sclk_pin), .csn_pin(csn_pin),
        .si_pin(si_pin), .so_out(so_out), .so_oe_n(so_oe_n), .chip_status(chip_status),
        .part_number(stat[0]), .chip_version(stat[1]), .freq_offset_est(stat[2]),
        .checksum_stat(stat[3]), .signal_strength(stat[4]), .radio_state(stat[5]),
        .packet_pin_status(stat[6]), .rx_fill_count(stat[7]), .rx_fifo_data(rx_fifo_data),
        .rx_fifo_pop(rx_fifo_pop), .reset_strobe(stb[0]), .crystal_off_strobe(stb[1]),
        .calibrate_strobe(stb[2]), .receive_strobe(stb[3]), .idle_strobe(stb[4]),
        .power_down_strobe(stb[5]), .flush_rx_strobe(stb[6]), .no_op_strobe(stb[7]),
        .sleep_active(sleep_active), .output_sources(output_sources),
        .general_output_2(go2), .output2_oe_n(oe2_n), .general_output_1(go1),
        .output1_oe_n(oe1_n), .output_drive_strength(ds));
    sag_master_model i_master (.core_clk(core_clk), .so_out(so_out), .sclk_pin(sclk_pin),
        .csn_pin(csn_pin), .si_pin(si_pin));
    // FIFO head advances the edge after each pop
    assign rx_fifo_data = 8'hc0 + pops[7:0];
    always @(posedge core_clk) begin
        if (rx_fifo_pop === 1'b1) pops <= pops + 1;
        for (int i = 0; i < 8; i++) if (stb[i] === 1'b1) stb_cnt[i]++;
    end
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic r, input logic b, input logic [5:0] a, input int n);
        i_master.access(r, b, a, wr, n, rd);
    endtask
    task automatic rd1(input logic [5:0] a, input logic [7:0] exp);
        acc(1'b1, 1'b0, a, 1);
        chk(rd[0], exp);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        rd1(6'h00, 8'h29);
        rd1(6'h01, 8'h2e);
        chk(oe1_n, 1'b1);
        chk(oe2_n, 1'b0);
        chk(so_oe_n, 1'b1);
        chk(ds, 1'b0);
        chk(go2, output_sources[6'h29]);
    endtask
    task automatic t_write();
        wr[0] = 8'hff;
        wr[1] = 8'hc5;
        acc(1'b0, 1'b1, 6'h00, 2);
        acc(1'b1, 1'b1, 6'h00, 2);
        chk(rd[0], 8'h7f);
        chk(rd[1], 8'hc5);
        chk(ds, 1'b1);
        chk(go2, !output_sources[6'h3f]);
        chk(go1, !output_sources[6'h05]);
        chk(oe1_n, 1'b0);
    endtask
    task automatic t_sleep();
        sleep_active <= 1'b1;
        i_master.wait_cyc(20);
        rd1(6'h00, 8'h7f);
        rd1(6'h01, 8'hc5);
        sleep_active <= 1'b0;
    endtask
    task automatic t_status();
        logic [5:0] map [8];
        logic [7:0] exp;
        map = '{6'h30, 6'h31, 6'h32, 6'h33, 6'h34, 6'h35, 6'h38, 6'h3b};
        for (logic [5:0] a = 6'h30; a <= 6'h3d; a++) begin
            exp = 8'h00;
            for (int j = 0; j < 8; j++) if (map[j] == a) exp = stat[j];
            acc(1'b1, 1'b1, a, 1);
            chk(rd[0], exp);
        end
    endtask
    task automatic t_fifo();
        int p0;
        p0 = pops;
        acc(1'b1, 1'b1, 6'h3f, 3);
        for (int k = 0; k < 3; k++) chk(rd[k], 8'hc0 + 8'(p0 + k));
        rd1(6'h3f, 8'hc0 + 8'(p0 + 3));
        wr[0] = 8'h55;
        acc(1'b0, 1'b0, 6'h3f, 1);
        acc(1'b0, 1'b0, 6'h24, 1);
        rd1(6'h24, 8'h00);
        chk(8'(pops - p0), 8'h04);
        rd1(6'h01, 8'hc5);
    endtask
    task automatic t_strobe();
        logic [5:0] adr [8];
        adr = '{6'h30, 6'h32, 6'h33, 6'h34, 6'h36, 6'h39, 6'h3a, 6'h3d};
        // Reset strobe last, since it restores the configuration
        for (int i = 7; i >= 0; i--) begin
            acc(1'b0, 1'b0, adr[i], 0);
            chk(8'(stb_cnt[i]), 8'h01);
        end
        for (int i = 0; i < 8; i++) chk(8'(stb_cnt[i]), 8'h01);
        rd1(6'h01, 8'h2e);
    endtask
    initial begin
        rst = 1'b1;
        sleep_active = 1'b0;
        chip_status = 8'h0f;
        output_sources = 64'h5a3c_96f0_0ff0_c3a5;
        for (int i = 0; i < 8; i++) stat[i] = 8'h51 + 8'(i);
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        i_master.wait_cyc(4);
        t_reset();
        t_write();
        t_sleep();
        t_status();
        t_fifo();
        t_strobe();
        wrap_up();
    end
    initial begin
        repeat (100000) @(posedge core_clk);
        bad_count++;
        wrap_up();
    end
endmodule // spi_address_map_gdo_config_bench
`default_nettype wire
